// >>> rtl/aos_angle_shaping.sv
/*
 * Angle output shaping: the two configuration words, rotation sense,
 * input zero shift, input window check, scaling, output zero shift and
 * output limiting, as a four-stage pipeline.
 * Four cycles from angle_valid to out_valid; window flags are per-sample
 * levels that hold with out_angle until the next sample.
 * Configuration writes act at once, also on samples already in flight.
 * Assumes configuration words arrive through a simple word write port,
 * and neighbouring fields (input zero shift, gain, limited-range mode)
 * come in as steady levels.
 */
// Notes on behaviour
// R1: range word bit 25 is clamp enable, bit 24 wrap enable; four modes.
// R2: both clear: output wraps normally at a full turn.
// R3: wrap only: output rolls over at the high and low limits.
// R4: clamp only: output holds at the first limit it meets.
// R5: both set: wraps at a full turn and saturates to the limits.
// R6: ceiling in bits 23:12, checked before scaling, flags when exceeded.
// R7: ceiling all ones disables the upper check.
// R8: floor in bits 11:0, checked before scaling, flags when undercut.
// R9: floor zero disables the lower check.
// R10: ceiling and floor codes span zero to just under a full turn.
// R11: shaping word bit 25 picks filter bandwidth; set halves it.
// R12: shaping word bit 24 reverses rotation sense, before input shift.
// R13: output zero shift in bits 23:12 is signed two's complement.
// R14: output zero shift is added after scaling and window check.
// R15: high limit code in bits 11:6 lowers limit about 4 degrees per step.
// R16: low limit code in bits 5:0 raises limit about 4 degrees per step.
// R17: window check and scaling only act in limited-range mode.
// R18: angle arithmetic is 12-bit, wrapping modulo 4096 codes.
`timescale 1ns/1ps
module aos_angle_shaping #(
    parameter int ANGLE_W = 12,
    parameter int GAIN_W = 13
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [25:0] cfg_wdata,
    output logic [25:0] cfg_rd_data,
    input wire logic [ANGLE_W-1:0] in_zero_shift,
    input wire logic [GAIN_W-1:0] scale_gain,
    input wire logic limited_range,
    input wire logic angle_valid,
    input wire logic [ANGLE_W-1:0] angle_in,
    output logic out_valid,
    output logic [ANGLE_W-1:0] out_angle,
    output logic over_ceiling,
    output logic under_floor,
    output logic filter_bw_half
);

    if (ANGLE_W != aos_pkg::ANGLE_W) begin : g_bad_angle_w
        $error("angle width must be 12");
    end
    if (GAIN_W != aos_pkg::GAIN_W) begin : g_bad_gain_w
        $error("gain width must be 13");
    end

    // field layout must fit the 26-bit words
    if (aos_pkg::CEIL_LSB + aos_pkg::ANGLE_W > aos_pkg::CFG_W) begin : g_bad_ceil_pos
        $error("ceiling field runs past the word");
    end
    if (aos_pkg::ZSHIFT_LSB + aos_pkg::ANGLE_W > aos_pkg::CFG_W) begin : g_bad_shift_pos
        $error("output shift field runs past the word");
    end
    if (aos_pkg::HI_LIM_LSB + aos_pkg::LIM_CODE_W > aos_pkg::ZSHIFT_LSB) begin : g_bad_lim_pos
        $error("high limit field overlaps the output shift");
    end
    if (aos_pkg::ADDR_W != 8) begin : g_bad_addr_w
        $error("word address must be 8 bits");
    end

    // angle codes wrap at a full turn
    function automatic logic [11:0] turn_add(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[11:0];
    endfunction

    function automatic logic [11:0] turn_sub(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] diff;
        diff = {1'b0, a} - {1'b0, b};
        return diff[11:0];
    endfunction

    // configuration words
    logic [25:0] range_cfg_q, range_cfg_d;
    logic [25:0] shape_cfg_q, shape_cfg_d;
    logic wr_range, wr_shape;

    assign wr_range = cfg_wr && (cfg_addr == aos_pkg::RANGE_CHECK_OFS);
    assign wr_shape = cfg_wr && (cfg_addr == aos_pkg::OUTPUT_SHAPING_OFS);

    always_comb begin
        range_cfg_d = range_cfg_q;
        shape_cfg_d = shape_cfg_q;
        if (wr_range) begin
            range_cfg_d = cfg_wdata;
        end
        if (wr_shape) begin
            shape_cfg_d = cfg_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            range_cfg_q <= aos_pkg::RANGE_CHECK_RST;
            shape_cfg_q <= aos_pkg::OUTPUT_SHAPING_RST;
        end else begin
            range_cfg_q <= range_cfg_d;
            shape_cfg_q <= shape_cfg_d;
        end
    end

    // read-back of the addressed word, unmapped reads as zero
    logic [25:0] rd_data_q, rd_data_d;

    always_comb begin
        case (cfg_addr)
            aos_pkg::RANGE_CHECK_OFS: begin
                rd_data_d = range_cfg_q;
            end
            aos_pkg::OUTPUT_SHAPING_OFS: begin
                rd_data_d = shape_cfg_q;
            end
            default: begin
                rd_data_d = 26'h0000000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= 26'h0000000;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign cfg_rd_data = rd_data_q;

    // field decode
    logic clamp_en, wrap_en, sense_ccw, bw_half;
    logic [11:0] ceiling, floor_code, out_shift;
    logic [5:0] hi_code, lo_code;
    logic [11:0] hi_lim, lo_lim;
    aos_pkg::aos_lim_mode_t lim_mode;

    assign clamp_en = range_cfg_q[aos_pkg::CLAMP_EN_BIT]; // see R1
    assign wrap_en = range_cfg_q[aos_pkg::WRAP_EN_BIT]; // see R1
    assign ceiling = range_cfg_q[aos_pkg::CEIL_LSB +: aos_pkg::ANGLE_W];
    assign floor_code = range_cfg_q[aos_pkg::FLOOR_LSB +: aos_pkg::ANGLE_W];
    assign bw_half = shape_cfg_q[aos_pkg::BW_SEL_BIT];
    assign sense_ccw = shape_cfg_q[aos_pkg::SENSE_BIT];
    assign out_shift = shape_cfg_q[aos_pkg::ZSHIFT_LSB +: aos_pkg::ANGLE_W];
    assign hi_code = shape_cfg_q[aos_pkg::HI_LIM_LSB +: aos_pkg::LIM_CODE_W];
    assign lo_code = shape_cfg_q[aos_pkg::LO_LIM_LSB +: aos_pkg::LIM_CODE_W];
    assign lim_mode = aos_pkg::aos_lim_mode_t'({clamp_en, wrap_en}); // see R1
    assign hi_lim = aos_pkg::FULL_SCALE - aos_pkg::lim_steps(hi_code); // see R15
    assign lo_lim = aos_pkg::lim_steps(lo_code); // see R16

    // stage 1: rotation sense, then input zero shift
    aos_pkg::aos_sample_t s1_q, s1_d;
    logic [11:0] sensed;

    always_comb begin
        // reversing sense mirrors the angle about zero
        sensed = sense_ccw ? turn_sub(12'h000, angle_in) : angle_in; // see R12
        s1_d = '0;
        s1_d.valid = angle_valid;
        s1_d.angle = turn_sub(sensed, in_zero_shift); // see R18
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
        end else begin
            s1_q <= s1_d;
        end
    end

    // stage 2: window check and scaling
    aos_pkg::aos_sample_t s2_q, s2_d;
    logic win_over, win_under;
    logic [13:0] gain_full;
    logic [25:0] product;

    aos_window_chk u_window (
        .angle(s1_q.angle),
        .ceiling(ceiling),
        .floor_code(floor_code),
        .limited_range(limited_range),
        .over_ceiling(win_over),
        .under_floor(win_under)
    );

    always_comb begin
        // gain is one plus the 5.8 field, so zero means unity
        gain_full = {1'b0, scale_gain} + aos_pkg::GAIN_ONE;
        product = 26'(s1_q.angle) * 26'(gain_full);
        s2_d.valid = s1_q.valid;
        s2_d.over_ceiling = win_over; // see R6
        s2_d.under_floor = win_under; // see R8
        s2_d.angle = s1_q.angle;
        if (limited_range) begin // see R17
            // excess above a full turn wraps
            s2_d.angle = product[aos_pkg::GAIN_FRAC +: aos_pkg::ANGLE_W]; // see R18
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s2_q <= '0;
        end else begin
            s2_q <= s2_d;
        end
    end

    // stage 3: output zero shift
    aos_pkg::aos_sample_t s3_q, s3_d;

    always_comb begin
        s3_d = s2_q;
        // signed shift added modulo a full turn
        s3_d.angle = turn_add(s2_q.angle, out_shift); // see R13 see R14 see R18
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s3_q <= '0;
        end else begin
            s3_q <= s3_d;
        end
    end

    // stage 4: limiting
    logic [11:0] limited;

    // limits follow the live codes, so a write also moves samples in flight
    aos_limiter u_limiter (
        .clk(clk),
        .nrst(nrst),
        .sample_valid(s3_q.valid),
        .angle(s3_q.angle),
        .mode(lim_mode),
        .hi_lim(hi_lim),
        .lo_lim(lo_lim),
        .limited(limited)
    );

    logic out_valid_q, out_valid_d;
    logic [11:0] out_angle_q, out_angle_d;
    logic over_q, over_d;
    logic under_q, under_d;

    always_comb begin
        out_valid_d = s3_q.valid;
        out_angle_d = out_angle_q;
        over_d = over_q;
        under_d = under_q;
        // results hold between samples
        if (s3_q.valid) begin
            out_angle_d = limited; // see R2 see R3 see R4 see R5
            over_d = s3_q.over_ceiling;
            under_d = s3_q.under_floor;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_q <= 1'b0;
            out_angle_q <= 12'h000;
            over_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            out_angle_q <= out_angle_d;
            over_q <= over_d;
            under_q <= under_d;
        end
    end

    // bandwidth select runs on its own, outside the sample path
    logic bw_q, bw_d;

    always_comb begin
        bw_d = bw_half; // see R11
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bw_q <= 1'b0;
        end else begin
            bw_q <= bw_d;
        end
    end

    assign out_valid = out_valid_q;
    assign out_angle = out_angle_q;
    assign over_ceiling = over_q;
    assign under_floor = under_q;
    assign filter_bw_half = bw_q;

endmodule

// >>> rtl/aos_pkg.sv
/*
 * Constants, types and helpers shared by the angle output shaping block.
 * Assumes 12-bit angle codes where 4096 codes make one full turn.
 */
package aos_pkg;

    localparam int ANGLE_W = 12;
    localparam int GAIN_W = 13;
    localparam int CFG_W = 26;
    localparam int ADDR_W = 8;

    // word addresses of the two configuration words
    localparam logic [7:0] RANGE_CHECK_OFS = 8'h3C;
    localparam logic [7:0] OUTPUT_SHAPING_OFS = 8'h3D;
    localparam logic [25:0] RANGE_CHECK_RST = 26'h0000000;
    localparam logic [25:0] OUTPUT_SHAPING_RST = 26'h0000000;

    // range_check_config fields
    localparam int CLAMP_EN_BIT = 25;
    localparam int WRAP_EN_BIT = 24;
    localparam int CEIL_LSB = 12;
    localparam int FLOOR_LSB = 0;

    // output_shaping_config fields
    localparam int BW_SEL_BIT = 25;
    localparam int SENSE_BIT = 24;
    localparam int ZSHIFT_LSB = 12;
    localparam int HI_LIM_LSB = 6;
    localparam int LO_LIM_LSB = 0;
    localparam int LIM_CODE_W = 6;

    localparam logic [11:0] CEIL_OFF = 12'hFFF;
    localparam logic [11:0] FLOOR_OFF = 12'h000;
    localparam logic [11:0] FULL_SCALE = 12'hFFF;
    // unity gain in 5.8 unsigned form
    localparam logic [13:0] GAIN_ONE = 14'h0100;
    localparam int GAIN_FRAC = 8;
    // two limit steps, in codes (about 4 degrees each)
    localparam logic [6:0] LIM_STEP_X2 = 7'h5B;

    typedef enum logic [1:0] {
        LIM_NORMAL = 2'b00,
        LIM_ROLL_AT_LIMITS = 2'b01,
        LIM_HOLD_FIRST = 2'b10,
        LIM_WRAP_AND_SAT = 2'b11
    } aos_lim_mode_t;

    typedef enum logic [1:0] {
        HS_INSIDE,
        HS_HELD_HI,
        HS_HELD_LO
    } aos_hold_state_t;

    typedef struct packed {
        logic valid;
        logic over_ceiling;
        logic under_floor;
        logic [11:0] angle;
    } aos_sample_t;

    function automatic logic [11:0] lim_steps(input logic [5:0] code);
        logic [12:0] prod;
        prod = 13'(code) * 13'(LIM_STEP_X2);
        return prod[12:1];
    endfunction

endpackage

// >>> rtl/aos_window_chk.sv
/*
 * Input window comparison of the angle taken before scaling.
 * Assumes the angle already carries rotation sense and input zero shift.
 */
`timescale 1ns/1ps
module aos_window_chk (
    input wire logic [11:0] angle,
    input wire logic [11:0] ceiling,
    input wire logic [11:0] floor_code,
    input wire logic limited_range,
    output logic over_ceiling,
    output logic under_floor
);

    always_comb begin
        over_ceiling = 1'b0;
        under_floor = 1'b0;
        if (limited_range) begin // see R6 see R8 see R17
            // all-ones ceiling switches the upper check off
            if (ceiling != aos_pkg::CEIL_OFF) begin // see R7 see R10
                over_ceiling = angle > ceiling; // see R6
            end
            // zero floor switches the lower check off
            if (floor_code != aos_pkg::FLOOR_OFF) begin // see R9 see R10
                under_floor = angle < floor_code; // see R8
            end
        end
    end

endmodule

// >>> rtl/aos_limiter.sv
/*
 * Output limiting in the four clamp and roll-over modes.
 * Assumes hi_lim not below lo_lim; result is combinational, state clocked.
 */
`timescale 1ns/1ps
module aos_limiter (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic [11:0] angle,
    input wire aos_pkg::aos_lim_mode_t mode,
    input wire logic [11:0] hi_lim,
    input wire logic [11:0] lo_lim,
    output logic [11:0] limited
);

    aos_pkg::aos_hold_state_t state_q, state_d;
    logic above, below;

    always_comb begin
        above = angle > hi_lim;
        below = angle < lo_lim;
        state_d = state_q;
        limited = angle;
        case (mode)
            aos_pkg::LIM_NORMAL: begin
                state_d = aos_pkg::HS_INSIDE; // see R2
            end
            aos_pkg::LIM_ROLL_AT_LIMITS: begin
                state_d = aos_pkg::HS_INSIDE;
                if (above) begin // see R3
                    limited = lo_lim;
                end else if (below) begin
                    limited = hi_lim;
                end
            end
            aos_pkg::LIM_HOLD_FIRST: begin
                // remember which limit was met first, even across wrap
                if (!above && !below) begin // see R4
                    state_d = aos_pkg::HS_INSIDE;
                end else if (state_q == aos_pkg::HS_INSIDE) begin
                    state_d = above ? aos_pkg::HS_HELD_HI : aos_pkg::HS_HELD_LO;
                end
                if (state_d == aos_pkg::HS_HELD_HI) begin
                    limited = hi_lim;
                end else if (state_d == aos_pkg::HS_HELD_LO) begin
                    limited = lo_lim;
                end
            end
            aos_pkg::LIM_WRAP_AND_SAT: begin
                state_d = aos_pkg::HS_INSIDE;
                if (above) begin // see R5
                    limited = hi_lim;
                end else if (below) begin
                    limited = lo_lim;
                end
            end
            default: begin
                state_d = aos_pkg::HS_INSIDE;
            end
        endcase
        // hold state only moves on real samples
        if (!sample_valid) begin
            state_d = state_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= aos_pkg::HS_INSIDE;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// >>> verif/aos_angle_shaping_chk.sv
/* Port-level checks of the angle shaping top.
   Bound to the top from the bench; one clock domain. */
`timescale 1ns/1ps
module aos_angle_shaping_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [25:0] cfg_wdata,
    input wire logic [25:0] cfg_rd_data,
    input wire logic limited_range,
    input wire logic angle_valid,
    input wire logic out_valid,
    input wire logic [11:0] out_angle,
    input wire logic over_ceiling,
    input wire logic under_floor,
    input wire logic filter_bw_half
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_out_latency: assert property (angle_valid |-> ##4 out_valid)
        else $error("output strobe missing");
    a_valid_cause: assert property (out_valid |-> $past(angle_valid, 4))
        else $error("output strobe without sample");
    a_out_hold: assert property (!out_valid |-> $stable(out_angle) && $stable(over_ceiling)
        && $stable(under_floor)) else $error("output changed between samples");
    a_flags_lr: assert property (out_valid && !$past(limited_range, 3)
        |-> !over_ceiling && !under_floor) else $error("window flag outside limited range");
    a_rd_unmapped: assert property (cfg_addr != 8'h3C && cfg_addr != 8'h3D
        |=> cfg_rd_data == 26'h0000000) else $error("unmapped read not zero");
    a_wr_readback: assert property (cfg_wr && cfg_addr == 8'h3C ##1 !cfg_wr && cfg_addr == 8'h3C
        |=> cfg_rd_data == $past(cfg_wdata, 2)) else $error("range word readback wrong");
    a_rd_hold: assert property (!cfg_wr && !$past(cfg_wr) && $stable(cfg_addr) |=> $stable(cfg_rd_data))
        else $error("read data moved");
    a_bw_follow: assert property (cfg_wr && cfg_addr == 8'h3D
        |-> ##2 filter_bw_half == $past(cfg_wdata[25], 2)) else $error("bandwidth select wrong");
endmodule

// >>> verif/aos_ctrl_model.sv
/* Controller model: captures every shaped sample the block delivers.
   Assumes the block's clock and reset. */
`timescale 1ns/1ps
module aos_ctrl_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic out_valid,
    input wire logic [11:0] out_angle,
    input wire logic over_ceiling,
    input wire logic under_floor,
    output aos_pkg::aos_sample_t seen,
    output int n_seen
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seen <= '0;
            n_seen <= 0;
        end else if (out_valid) begin
            seen <= {1'b1, over_ceiling, under_floor, out_angle};
            n_seen <= n_seen + 1;
        end
    end
endmodule

// >>> verif/aos_angle_shaping_bench.sv
/* Directed bench for the angle shaping block.
   Assumes package, design, checker and controller model compiled first. */
`timescale 1ns/1ps
module aos_angle_shaping_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [25:0] cfg_wdata = 26'h0000000;
    logic [25:0] cfg_rd_data;
    logic [11:0] in_zero_shift = 12'h000;
    logic [12:0] scale_gain = 13'h0000;
    logic limited_range = 1'b0;
    logic angle_valid = 1'b0;
    logic [11:0] angle_in = 12'h000;
    logic out_valid;
    logic [11:0] out_angle;
    logic over_ceiling;
    logic under_floor;
    logic filter_bw_half;
    aos_pkg::aos_sample_t seen;
    int n_seen;
    int fails = 0;
    int n_checks = 0;

    always #20 clk = ~clk;

    aos_angle_shaping dut_u (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rd_data(cfg_rd_data), .in_zero_shift(in_zero_shift),
        .scale_gain(scale_gain), .limited_range(limited_range), .angle_valid(angle_valid),
        .angle_in(angle_in), .out_valid(out_valid), .out_angle(out_angle),
        .over_ceiling(over_ceiling), .under_floor(under_floor), .filter_bw_half(filter_bw_half));

    aos_ctrl_model ctrl_u (.clk(clk), .nrst(nrst), .out_valid(out_valid), .out_angle(out_angle),
        .over_ceiling(over_ceiling), .under_floor(under_floor), .seen(seen), .n_seen(n_seen));

    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [25:0] dat);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = adr;
        cfg_wdata = dat;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    // word shows one rising edge after the address
    task automatic rd(input logic [7:0] adr, input logic [25:0] exp);
        cfg_addr = adr;
        repeat (2) @(negedge clk);
        chk(cfg_rd_data, exp);
    endtask

    // f holds limited range, expected over flag, expected under flag
    task automatic run(input logic [25:0] rw, input logic [25:0] sw, input logic [2:0] f,
        input logic [11:0] a, input logic [11:0] e);
        wr(8'h3C, rw);
        rd(8'h3C, rw);
        wr(8'h3D, sw);
        rd(8'h3D, sw);
        limited_range = f[2];
        angle_valid = 1'b1;
        angle_in = a;
        @(negedge clk);
        angle_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk(out_valid, 1'b1);
        chk(out_angle, e);
        chk({over_ceiling, under_floor}, f[1:0]);
        chk(filter_bw_half, sw[25]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        rd(8'h3C, 26'h0000000);
        rd(8'h3D, 26'h0000000);
        wr(8'h3E, 26'h3FFFFFF);
        rd(8'h3E, 26'h0000000);
        rd(8'h3C, 26'h0000000);
        run(26'h0000000, 26'h0800000, 3'h0, 12'h100, 12'h900);
        run(26'h0000000, 26'h3800000, 3'h0, 12'h100, 12'h700);
        run(26'h0000000, 26'h07FF000, 3'h0, 12'h900, 12'h0FF);
        run(26'h1000000, 26'h0000082, 3'h0, 12'hFA0, 12'hFA0);
        run(26'h1000000, 26'h0000082, 3'h0, 12'hFB0, 12'h05B);
        run(26'h1000000, 26'h0000082, 3'h0, 12'h010, 12'hFA4);
        run(26'h2000000, 26'h0000082, 3'h0, 12'h100, 12'h100);
        run(26'h2000000, 26'h0000082, 3'h0, 12'hFB0, 12'hFA4);
        run(26'h2000000, 26'h0000082, 3'h0, 12'h010, 12'hFA4);
        run(26'h2000000, 26'h0000082, 3'h0, 12'h200, 12'h200);
        run(26'h3000000, 26'h0000082, 3'h0, 12'hFB0, 12'hFA4);
        run(26'h3000000, 26'h0000082, 3'h0, 12'h010, 12'h05B);
        run(26'h0000000, 26'h0000082, 3'h0, 12'hFB0, 12'hFB0);
        run(26'h0800100, 26'h0000000, 3'h6, 12'h900, 12'h900);
        run(26'h0800100, 26'h0000000, 3'h5, 12'h080, 12'h080);
        run(26'h0800100, 26'h0000000, 3'h0, 12'h900, 12'h900);
        run(26'h0FFF000, 26'h0000000, 3'h4, 12'hFFF, 12'hFFF);
        run(26'h0FFF000, 26'h0000000, 3'h4, 12'h000, 12'h000);
        scale_gain = 13'h0100;
        in_zero_shift = 12'h010;
        run(26'h0400000, 26'h0001000, 3'h4, 12'h310, 12'h601);
        run(26'h0400000, 26'h0001000, 3'h0, 12'h310, 12'h301);
        run(26'h0000000, 26'h1000000, 3'h0, 12'h100, 12'hEF0);
        @(negedge clk);
        chk(26'(n_seen), 26'h0000015);
        chk(26'(seen), {11'h000, 1'b1, 2'b00, 12'hEF0});
        summarize();
    end
endmodule

bind aos_angle_shaping aos_angle_shaping_chk chk_u (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rd_data(cfg_rd_data),
    .limited_range(limited_range), .angle_valid(angle_valid), .out_valid(out_valid),
    .out_angle(out_angle), .over_ceiling(over_ceiling), .under_floor(under_floor),
    .filter_bw_half(filter_bw_half));
